// *** lgbl_host.sv ***
// Purpose: host side serial writer for the brightness latch
// Assumes: clock idles low between frames, 15 ns period
// Notes: released data line shows the inverse of its last bit
module lgbl_host
(
   // serial pins
   output logic serial_clock_in,
   output logic serial_data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
   end
   // msb first, whole frame, then the clock stands still
   task automatic send(input logic [lgbl_pkg::SHIFT_W-1:0] w);
      // start off the pclk grid so the two clocks keep no phase relation
      #4.3;
      for (int i = lgbl_pkg::SHIFT_W - 1; i >= 0; i--)
      begin
         serial_data_in = w[i];
         #7.5 serial_clock_in = 1'b1;
         #7.5 serial_clock_in = 1'b0;
      end
      serial_data_in = ~w[0];
   endtask
endmodule

// *** lgbl_link_shift.sv ***
// Purpose: serial shift register on the serial clock domain
// Assumes: serial clock stands still between frames
// Notes: gray edge count to pclk; aliases at 8 or more edges per pclk period
module lgbl_link_shift
(
   // link clock and reset
   input wire logic serial_clock_in,
   input wire logic presetn,
   // serial pins
   input wire logic serial_data_in,
   output logic serial_data_out,
   // toward pclk domain
   output logic [lgbl_pkg::SHIFT_W-1:0] shift_word,
   output logic [lgbl_pkg::EDGE_W-1:0] edge_gray
);
   import lgbl_pkg::*;

   lgbl_link_state_t s_q;
   lgbl_link_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.shift = {s_q.shift[SHIFT_W-2:0], serial_data_in}; // RULE12
      // gray count: one bit moves per edge, so a sample is never torn
      s_d.edge_bin = s_q.edge_bin + EDGE_W'(1);
      s_d.edge_gray = s_d.edge_bin ^ (s_d.edge_bin >> 1);
   end

   // contents are don't-care at power-up; zero only for a clean start
   always_ff @(posedge serial_clock_in or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign shift_word = s_q.shift;
   assign edge_gray = s_q.edge_gray;
   assign serial_data_out = s_q.shift[SHIFT_W-1];
endmodule

// *** lgbl_pkg.sv ***
// Purpose: shared constants and types of the group brightness latch
// Assumes: pclk at 10 MHz, apb with 32-bit data
// Notes: latch bit positions follow the serial word layout
package lgbl_pkg;
   localparam int SHIFT_W = 224;
   localparam int LATCH_W = 218;
   localparam int BC_W = 7;
   localparam int GS_W = 16;
   localparam int NUM_CH = 12;
   localparam int CH_PER_GROUP = 4;
   localparam int CNT_W = 16;
   // gray edge count wraps at 8: that must exceed the serial edges in one pclk period
   localparam int EDGE_W = 3;
   // latch field positions
   localparam int EDGE_SEL_BIT = 217;
   localparam int EXT_CLK_BIT = 216;
   localparam int REPEAT_BIT = 215;
   localparam int TIMING_RST_BIT = 214;
   localparam int BLANK_BIT = 213;
   localparam int BC_BLUE_LSB = 206;
   localparam int BC_GREEN_LSB = 199;
   localparam int BC_RED_LSB = 192;
   localparam int GS_LSB = 0;
   localparam logic BLANK_RESET = 1'b1;
   localparam logic [BC_W-1:0] BC_FULL = 7'h7f;
   localparam logic [GS_W-1:0] GS_HOLD = 16'h0000;
   // apb map
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_BRIGHT = 8'h04;
   localparam logic [7:0] ADDR_GS_COUNT = 8'h08;
   localparam logic [7:0] ADDR_LATCH_DLY = 8'h0c;
   localparam int STATUS_BLANK_POS = 0;
   localparam int STATUS_EDGE_POS = 1;
   localparam int STATUS_EXT_POS = 2;
   localparam int STATUS_CNT_LSB = 16;
   localparam int BRIGHT_RED_LSB = 0;
   localparam int BRIGHT_GREEN_LSB = 8;
   localparam int BRIGHT_BLUE_LSB = 16;
   // timing
   localparam int PCLK_PERIOD_NS = 100;
   localparam int LATCH_DLY_NS = 1000;
   localparam int LATCH_DLY_CYC = (LATCH_DLY_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] LATCH_DLY_RESET = CNT_W'(LATCH_DLY_CYC);

   typedef struct packed {
      logic [SHIFT_W-1:0] shift;
      logic [EDGE_W-1:0] edge_bin;
      logic [EDGE_W-1:0] edge_gray;
   } lgbl_link_state_t;

   typedef struct packed {
      logic [2:0][EDGE_W-1:0] tog_sync;
      logic [EDGE_W-1:0] tog_seen;
      logic armed;
      logic [CNT_W-1:0] idle_cnt;
      logic [CNT_W-1:0] latch_dly;
      logic [LATCH_W-1:0] latch;
      logic [GS_W-1:0] gs_cnt;
      logic [CNT_W-1:0] strobe_cnt;
      logic strobe;
      logic [NUM_CH-1:0] ch_on;
      logic [NUM_CH*BC_W-1:0] ch_cur;
      logic [31:0] prdata;
      logic pslverr;
   } lgbl_state_t;
endpackage

// *** lgbl_top.sv ***
// Purpose: group brightness latch of a 12-channel led sink driver
// Assumes: pclk 10 MHz; serial clock idle between writes
// Notes: brightness is set only from the serial word; apb sees state
// Function
// [RULE1] one 7-bit brightness per colour group, 128 steps
// [RULE2] a group's brightness drives all four of its outputs
// [RULE3] brightness loads only through the serial input
// [RULE4] a new latched brightness reaches the outputs at once; here channel_current is registered and follows one pclk after the latch load
// [RULE5] blank bit 213 is set at power-up, all outputs off
// [RULE6] only the blank bit is initialised at power-up; reset here also zeroes the rest of the latch
// [RULE7] host clears blank in the same write carrying brightness
// [RULE8] group current is brightness over 127; zero gives zero
// [RULE9] 7fh gives full channel current on enabled outputs
// [RULE10] latch strobe comes a fixed delay after the last serial edge
// [RULE11] on/off switching follows the grayscale data in the latch
// [RULE12] each serial rising edge shifts data in at the lsb
// [RULE13] blank holds grayscale counter at 0000h, outputs off
// [RULE14] brightness fields and blank latch together in one step
//
// Implementation choices: the APB register port and the register addresses.
module lgbl_top
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   output logic serial_data_out,
   // channel drive
   output logic [lgbl_pkg::NUM_CH-1:0] channel_output,
   output logic [lgbl_pkg::NUM_CH*lgbl_pkg::BC_W-1:0] channel_current,
   output logic latch_strobe
);
   import lgbl_pkg::*;

   logic [SHIFT_W-1:0] shift_word;
   logic [EDGE_W-1:0] edge_gray;
   lgbl_state_t s_q;
   lgbl_state_t s_d;

   lgbl_link_shift u_link
   (
      .serial_clock_in(serial_clock_in),
      .presetn(presetn),
      .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out),
      .shift_word(shift_word),
      .edge_gray(edge_gray)
   );

   logic setup_phase;
   logic access_wr;
   logic sync_stable;
   logic link_busy;
   logic dly_hit;
   logic [BC_W-1:0] bc_red;
   logic [BC_W-1:0] bc_green;
   logic [BC_W-1:0] bc_blue;

   assign setup_phase = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   // second and third stage agree before a change is believed
   assign sync_stable = (s_q.tog_sync[1] == s_q.tog_sync[2]);
   // a moving count, or a settled new one, means the link is not idle yet
   assign link_busy = ~sync_stable | (s_q.tog_sync[2] != s_q.tog_seen);
   assign dly_hit = s_q.armed & (s_q.idle_cnt + 16'h0001 >= s_q.latch_dly);
   assign bc_red = s_q.latch[BC_RED_LSB +: BC_W]; // RULE1
   assign bc_green = s_q.latch[BC_GREEN_LSB +: BC_W];
   assign bc_blue = s_q.latch[BC_BLUE_LSB +: BC_W];

   always_comb
   begin
      logic [BC_W-1:0] grp;
      logic [GS_W-1:0] gs_val;
      logic [31:0] rd;
      logic err;
      grp = '0;
      gs_val = '0;
      rd = '0;
      err = 1'b0;
      s_d = s_q;

      s_d.tog_sync = {s_q.tog_sync[1:0], edge_gray};
      s_d.strobe = 1'b0;

      // strobe a fixed idle time after the last edge, not on a count
      if (link_busy)
      begin
         // only a settled count is taken as seen
         if (sync_stable)
         begin
            s_d.tog_seen = s_q.tog_sync[2];
         end
         s_d.armed = 1'b1;
         s_d.idle_cnt = '0; // RULE10
      end
      else if (dly_hit)
      begin
         s_d.armed = 1'b0;
         s_d.idle_cnt = '0;
         s_d.strobe = 1'b1; // RULE10
         // shift word is quiet here: the serial clock has stopped
         s_d.latch = shift_word[LATCH_W-1:0]; // RULE14 RULE3 RULE7
         s_d.strobe_cnt = s_q.strobe_cnt + 16'h0001;
      end
      else if (s_q.armed)
      begin
         s_d.idle_cnt = s_q.idle_cnt + 16'h0001;
      end

      // grayscale counter on the internal 100 ns reference
      if (s_q.latch[BLANK_BIT])
      begin
         s_d.gs_cnt = GS_HOLD; // RULE13
      end
      else
      begin
         s_d.gs_cnt = s_q.gs_cnt + 16'h0001;
      end

      for (int i = 0; i < NUM_CH; i++)
      begin
         case (i / CH_PER_GROUP)
            0: grp = bc_red;
            1: grp = bc_green;
            default: grp = bc_blue;
         endcase
         gs_val = s_q.latch[GS_LSB + i*GS_W +: GS_W];
         // switching uses latch content as it stood before this strobe
         s_d.ch_on[i] = ~s_q.latch[BLANK_BIT] & (s_q.gs_cnt < gs_val); // RULE11 RULE13
         // current code scales linearly: 0 is off, 7fh is full scale
         s_d.ch_cur[i*BC_W +: BC_W] = grp; // RULE2 RULE4 RULE8 RULE9
      end

      // apb: answer data captured in setup, presented in access
      if (paddr == ADDR_STATUS)
      begin
         rd[STATUS_BLANK_POS] = s_q.latch[BLANK_BIT];
         rd[STATUS_EDGE_POS] = s_q.latch[EDGE_SEL_BIT];
         rd[STATUS_EXT_POS] = s_q.latch[EXT_CLK_BIT];
         rd[STATUS_CNT_LSB +: CNT_W] = s_q.strobe_cnt;
      end
      else if (paddr == ADDR_BRIGHT)
      begin
         rd[BRIGHT_RED_LSB +: BC_W] = bc_red;
         rd[BRIGHT_GREEN_LSB +: BC_W] = bc_green;
         rd[BRIGHT_BLUE_LSB +: BC_W] = bc_blue;
      end
      else if (paddr == ADDR_GS_COUNT)
      begin
         rd[GS_W-1:0] = s_q.gs_cnt;
      end
      else if (paddr == ADDR_LATCH_DLY)
      begin
         rd[CNT_W-1:0] = s_q.latch_dly;
      end
      else
      begin
         err = 1'b1;
      end
      // only the delay register is writable; brightness stays serial-only
      if (pwrite && paddr != ADDR_LATCH_DLY)
      begin
         err = 1'b1; // RULE3
      end
      if (setup_phase)
      begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rd;
         s_d.pslverr = err;
      end
      if (access_wr && paddr == ADDR_LATCH_DLY)
      begin
         // zero would fire like one, on the first idle cycle; keep at least one cycle
         s_d.latch_dly = (pwdata[CNT_W-1:0] == '0) ? 16'h0001 : pwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.latch[BLANK_BIT] <= BLANK_RESET; // RULE5 RULE6
         s_q.latch_dly <= LATCH_DLY_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pslverr = psel & penable & s_q.pslverr;
   assign pready = 1'b1;
   assign channel_output = s_q.ch_on;
   assign channel_current = s_q.ch_cur;
   assign latch_strobe = s_q.strobe;
endmodule

// *** lgbl_top_asserts.sv ***
// Purpose: port assertions for the group brightness latch
// Assumes: all checks run on pclk; link pins sampled there
// Notes: bound to every lgbl_top instance
module lgbl_chk
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link and drive
   input wire logic serial_clock_in,
   input wire logic [lgbl_pkg::NUM_CH-1:0] channel_output,
   input wire logic [lgbl_pkg::NUM_CH*lgbl_pkg::BC_W-1:0] channel_current,
   input wire logic latch_strobe
);
   import lgbl_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic seen_q;
   // outputs must stay dark until the first latch load
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         seen_q <= 1'b0;
      else if (latch_strobe)
         seen_q <= 1'b1;
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_strobe_pulse: assert property (latch_strobe |=> !latch_strobe)
      else $error("strobe longer than one cycle");
   a_group_same: assert property (
      channel_current == {{4{channel_current[62:56]}}, {4{channel_current[34:28]}},
      {4{channel_current[6:0]}}}) else $error("group currents differ");
   a_cur_hold: assert property (!latch_strobe |=> $stable(channel_current))
      else $error("current changed without strobe");
   a_ro_refuse: assert property (
      psel && penable && pwrite && paddr < ADDR_LATCH_DLY |-> pslverr)
      else $error("read-only write accepted");
   a_unmapped_err: assert property (
      psel && penable && paddr > ADDR_LATCH_DLY |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   a_strobe_idle: assert property ($changed(serial_clock_in) |=> !latch_strobe [*2])
      else $error("strobe while link active");
   a_blank_off: assert property (!seen_q |-> channel_output == '0)
      else $error("output on before first load");
endmodule
bind lgbl_top lgbl_chk i_lgbl_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .serial_clock_in, .channel_output, .channel_current,
   .latch_strobe);

// *** test_led_group_brightness_latch.sv ***
// Purpose: self-checking bench for the group brightness latch
// Assumes: pclk 100 ns, link clock 15 ns from the host model
// Notes: latch delay cut to 2 over apb to keep frames short
module test_led_group_brightness_latch;
   timeunit 1ns;
   timeprecision 100ps;
   import lgbl_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, serial_clock_in, serial_data_in, serial_data_out, latch_strobe;
   logic [NUM_CH-1:0] channel_output;
   logic [NUM_CH*BC_W-1:0] channel_current;
   logic [SHIFT_W-1:0] w;
   logic [BC_W-1:0] bc [3];
   logic [31:0] exp_q [$];
   int err_total = 0, tests_run = 0, scnt = 0, n;
   always #50 pclk = ~pclk;
   lgbl_top i_lgbl_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .serial_clock_in, .serial_data_in, .serial_data_out,
      .channel_output, .channel_current, .latch_strobe);
   lgbl_host i_lgbl_host (.serial_clock_in, .serial_data_in);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // frame 0 full scale, 1 zero, 2 blanked, rest random
   task automatic frame(input int f);
      for (int k = 0; k < 7; k++) w[32*k+:32] = $urandom();
      for (int g = 0; g < 3; g++) bc[g] = f == 0 ? BC_FULL : f == 1 ? 7'h00 : 7'($urandom());
      w[BC_RED_LSB+:BC_W] = bc[0];
      w[BC_GREEN_LSB+:BC_W] = bc[1];
      w[BC_BLUE_LSB+:BC_W] = bc[2];
      w[BLANK_BIT] = f == 2;
      w[GS_LSB+:NUM_CH*GS_W] = {6{32'h0000ffff}};
      exp_q.push_back({9'h0, bc[2], 1'b0, bc[1], 1'b0, bc[0]});
      i_lgbl_host.send(w);
      n = 0;
      @(negedge pclk);
      while (latch_strobe !== 1'b1)
      begin
         @(negedge pclk);
         n++;
      end
      scnt++;
      chk(32'(n >= 2 && n <= 10), 32'h1);
      chk(serial_data_out, w[SHIFT_W-1]);
      repeat (2) @(negedge pclk);
      for (int i = 0; i < NUM_CH; i++) chk(channel_current[BC_W*i+:BC_W], bc[i/4]);
      apb(1'b0, ADDR_BRIGHT, '0);
      chk(rd & 32'h7f7f7f, exp_q.pop_front());
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd & 32'hffff0007, {16'(scnt), 13'h0, w[EXT_CLK_BIT], w[EDGE_SEL_BIT], w[BLANK_BIT]});
      apb(1'b0, ADDR_GS_COUNT, '0);
      if (f == 2) chk(rd, '0);
      chk(channel_output, f == 2 ? 12'h000 : 12'h555);
   endtask
   initial
   begin
      #3000000;
      err_total++;
      end_sim();
   end
   initial
   begin
      void'($urandom(72));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd & 32'hffff0001, 32'h1);
      apb(1'b0, ADDR_LATCH_DLY, '0);
      chk(rd, 32'(LATCH_DLY_RESET));
      apb(1'b1, ADDR_LATCH_DLY, '0);
      apb(1'b0, ADDR_LATCH_DLY, '0);
      chk(rd, 32'h1);
      apb(1'b1, ADDR_BRIGHT, 32'h007f7f7f);
      chk(err, 32'h1);
      apb(1'b0, ADDR_BRIGHT, '0);
      chk(rd, '0);
      apb(1'b0, 8'h10, '0);
      chk(err, 32'h1);
      chk(rd, '0);
      apb(1'b1, ADDR_LATCH_DLY, 32'h2);
      for (int f = 0; f < 6; f++) frame(f);
      end_sim();
   end
endmodule
